//--- hw/flash_front.sv
// serial flash front end: framing, pause, protection, secure area
`timescale 1ns/1ps
// Behaviour
// [RQ1] top select 0: levels 0/1/2/other protect none, top block, top two, all
// [RQ2] top select 1: levels 0/1/2/other protect none, block 0, blocks 0-1, all
// [RQ3] chip erase accepted only when all four level bits are zero
// [RQ4] secure area 8K bits: 000-1ff customer half, 200-3ff factory half
// [RQ5] security bit 0 shows the factory lock of the second half
// [RQ6] write-security command sets customer lock, security bit 1
// [RQ7] a locked secure half refuses every further change
// [RQ8] enter/exit commands bracket secure mode; array access denied inside
// [RQ9] array spans 000000h-03ffffh; sectors, 32KB and 64KB blocks size-aligned
// [RQ10] unknown command: output high impedance until next select fall
// [RQ11] valid command keeps device active until select rises
// [RQ12] inputs sampled on clock rise, outputs change on clock fall
// [RQ13] host may end read-type frames after any output bit
// [RQ14] write-type frames not ending on a byte boundary are rejected
// [RQ15] while internal write runs, array and write requests are ignored
// [RQ16] host polls status for ready before each command
// [RQ17] pause starts on pause low while clock low, else at clock fall; the output is released only at a clock fall in both cases
// [RQ18] pause ends on pause high while clock low, else at clock fall; the output is driven again only at a clock fall in both cases
// [RQ19] during pause output is high impedance and input ignored
// [RQ20] a pause never halts an internal operation in progress
// [RQ21] select high during pause resets interface; resume needs pause high
// [RQ22] pause disabled in four-line mode
// [RQ23] data-changing commands need the write enable latch set
// [RQ24] write protect pin locks level and disable bits, not in four-line mode
// [RQ25] program or erase into a protected block is ignored
module flash_front #(
   parameter logic [7:0] CMD_ENTER_SECURE = 8'hb1,  // arbitrary default
   parameter logic [7:0] CMD_EXIT_SECURE  = 8'hc1,  // arbitrary default
   parameter logic [7:0] CMD_WRITE_SECURE = 8'h2f   // arbitrary default
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   input  wire logic        i_sclk,
   input  wire logic        i_cs_n,
   input  wire logic        i_si,
   input  wire logic        i_hold_n,
   input  wire logic        i_wp_n,
   input  wire logic        i_quad_mode,
   input  wire logic        i_top_bottom_select,
   input  wire logic        i_factory_otp_lock,
   input  wire logic        i_busy,
   output logic             o_so,
   output logic             o_so_oe,
   output logic [3:0]       o_protect_level,
   output logic             o_status_write_disable,
   output logic             o_write_enable_latch,
   output logic [1:0]       o_security_reg,
   output logic             o_secure_area_mode,
   output logic             o_prog_req,
   output logic             o_otp_prog_req,
   output logic             o_erase_req,
   output logic [1:0]       o_erase_kind,
   output logic [17:0]      o_addr,
   output logic             o_cmd_reject
);

   // ------------------------------------------------------------
   // state types
   // ------------------------------------------------------------
   typedef struct packed {
      logic        frame_tog;
      logic [2:0]  bit_cnt;
      logic [2:0]  byte_cnt;
      logic [7:0]  shift;
      logic [7:0]  opcode;
      logic [23:0] addr;
      logic [7:0]  value;
      logic        standby;
      logic [8:0]  sync1;
      logic [8:0]  sync2;
   } link_s;

   typedef struct packed {
      logic       so;
      logic       so_oe;
      logic [2:0] out_idx;
   } out_s;

   typedef struct packed {
      logic        cs1;
      logic        cs2;
      logic        cs3;
      logic        wp1;
      logic        wp2;
      logic        busy;
      logic        quad;
      logic        last_tog;
      logic [3:0]  level;
      logic        swd;
      logic        write_enable_latch;
      logic [1:0]  sec;
      logic        secure;
      logic        prog_req;
      logic        otp_req;
      logic        erase_req;
      logic [1:0]  erase_kind;
      logic [17:0] addr;
      logic        reject;
   } sys_s;

   link_s l_r, l_nxt;
   out_s  o_r, o_nxt;
   sys_s  s_r, s_nxt;
   logic  started_r;
   logic  frame_done;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // protected-block decode for one 64KB block
   function automatic logic blk_protected(input logic [3:0] lvl, input logic tb,
                                          input logic [1:0] blk);
      case (lvl)
         flash_front_pkg::LEVEL_NONE: blk_protected = 1'b0;
         flash_front_pkg::LEVEL_ONE:
            blk_protected = tb ? (blk == flash_front_pkg::BLK_FIRST)
                               : (blk == flash_front_pkg::BLK_LAST);
         flash_front_pkg::LEVEL_TWO:
            blk_protected = tb ? (blk <= flash_front_pkg::BLK_SECOND)
                               : (blk > flash_front_pkg::BLK_SECOND);
         default: blk_protected = 1'b1;
      endcase
   endfunction

   // opcodes this front end answers to
   function automatic logic known_op(input logic [7:0] op);
      known_op = op inside {flash_front_pkg::CMD_WRITE_ENABLE, flash_front_pkg::CMD_WRITE_DISABLE,
                            flash_front_pkg::CMD_READ_STATUS, flash_front_pkg::CMD_WRITE_STATUS,
                            flash_front_pkg::CMD_READ, flash_front_pkg::CMD_FAST_READ,
                            flash_front_pkg::CMD_PAGE_PROGRAM, flash_front_pkg::CMD_SECTOR_ERASE,
                            flash_front_pkg::CMD_HALF_ERASE, flash_front_pkg::CMD_BLOCK_ERASE,
                            flash_front_pkg::CMD_CHIP_ERASE_A, flash_front_pkg::CMD_CHIP_ERASE_B,
                            CMD_ENTER_SECURE, CMD_EXIT_SECURE, CMD_WRITE_SECURE};
   endfunction

   // ------------------------------------------------------------
   // link domain: shift-in on serial clock rise
   // ------------------------------------------------------------
   // first edge of a frame seen since select fell
   always_ff @(posedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         started_r <= 1'b0;
      end else begin
         started_r <= 1'b1;
      end
   end

   // frame bits, opcode and address; payload stays put after the frame
   always_comb begin
      l_nxt = l_r;
      l_nxt.sync1 = {s_r.quad, s_r.swd, 1'b0, s_r.level, s_r.write_enable_latch, s_r.busy};
      l_nxt.sync2 = l_r.sync1;
      if (!started_r) begin
         // last_tog moves only between frames, so it is settled here
         l_nxt.frame_tog = ~s_r.last_tog;
         l_nxt.bit_cnt   = '0;
         l_nxt.byte_cnt  = '0;
         l_nxt.standby   = 1'b0;
      end
      // [RQ19] input ignored in pause
      // [RQ22] pause off in four-line mode
      // [RQ12] sample on rise
      if (i_hold_n || l_r.sync2[flash_front_pkg::SYNC_QUAD]) begin
         l_nxt.shift = {l_nxt.shift[6:0], i_si};
         if (l_nxt.bit_cnt == flash_front_pkg::LAST_BIT) begin
            case (l_nxt.byte_cnt)
               3'h0: begin
                  l_nxt.opcode = l_nxt.shift;
                  // [RQ10] unknown goes standby
                  l_nxt.standby = !known_op(l_nxt.shift);
               end
               3'h1: begin
                  l_nxt.value = l_nxt.shift;
                  l_nxt.addr  = {l_nxt.addr[15:0], l_nxt.shift};
               end
               3'h2, 3'h3: l_nxt.addr = {l_nxt.addr[15:0], l_nxt.shift};
               // data bytes past the address leave it alone
               default: l_nxt.addr = l_nxt.addr;
            endcase
            if (l_nxt.byte_cnt != flash_front_pkg::BYTES_SAT) begin
               l_nxt.byte_cnt = l_nxt.byte_cnt + 3'h1;
            end
         end
         l_nxt.bit_cnt = l_nxt.bit_cnt + 3'h1;
      end
   end

   always_ff @(posedge i_sclk) begin
      l_r <= l_nxt;
   end

   // ------------------------------------------------------------
   // link domain: status shift-out on serial clock fall
   // ------------------------------------------------------------
   // [RQ11] valid read stays active
   // [RQ12] change on fall
   always_comb begin
      o_nxt = o_r;
      o_nxt.so_oe = 1'b0;
      if (l_r.opcode == flash_front_pkg::CMD_READ_STATUS && l_r.byte_cnt != '0
          && !l_r.standby) begin
         // [RQ17] pause taken at clock fall only
         // [RQ18] release at clock fall only
         if (i_hold_n || l_r.sync2[flash_front_pkg::SYNC_QUAD]) begin
            o_nxt.so_oe   = 1'b1;
            o_nxt.so      = l_r.sync2[flash_front_pkg::STATUS_MSB - o_r.out_idx];
            o_nxt.out_idx = o_r.out_idx + 3'h1;
         end
      end else begin
         o_nxt.out_idx = '0;
      end
   end

   // [RQ21] select high clears the interface
   always_ff @(negedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         o_r <= '0;
      end else begin
         o_r <= o_nxt;
      end
   end

   // ------------------------------------------------------------
   // system domain: command evaluation at frame end
   // ------------------------------------------------------------
   // link payload is read only once synchronised select says it is still
   always_comb begin
      logic        on_byte;
      logic        hw_lock;
      logic        ok_wr;
      logic        acc;
      logic        is_wr;
      logic [17:0] a;
      logic [1:0]  blk;
      on_byte = (l_r.bit_cnt == '0);
      hw_lock = s_r.swd && !s_r.wp2 && !s_r.quad;
      a       = l_r.addr[flash_front_pkg::ADDR_BITS-1:0];
      blk     = a[flash_front_pkg::BLK_LSB +: 2];
      // [RQ14] byte boundary
      // [RQ15] nothing taken while busy
      // [RQ23] latch required
      ok_wr   = on_byte && s_r.write_enable_latch && !s_r.busy && !l_r.standby;
      acc     = 1'b0;
      is_wr   = 1'b1;
      s_nxt = s_r;
      s_nxt.cs1  = i_cs_n;
      s_nxt.cs2  = s_r.cs1;
      s_nxt.cs3  = s_r.cs2;
      s_nxt.wp1  = i_wp_n;
      s_nxt.wp2  = s_r.wp1;
      // [RQ20] busy tracked through pause
      s_nxt.busy = i_busy;
      s_nxt.quad = i_quad_mode;
      // [RQ5] factory lock shown
      s_nxt.sec[flash_front_pkg::SEC_FACTORY] = i_factory_otp_lock;
      s_nxt.prog_req  = 1'b0;
      s_nxt.otp_req   = 1'b0;
      s_nxt.erase_req = 1'b0;
      s_nxt.reject    = 1'b0;
      frame_done = s_r.cs2 && !s_r.cs3 && (l_r.frame_tog != s_r.last_tog);
      if (frame_done) begin
         s_nxt.last_tog = l_r.frame_tog;
         case (l_r.opcode)
            flash_front_pkg::CMD_WRITE_ENABLE: begin
               if (on_byte && !s_r.busy && l_r.byte_cnt == flash_front_pkg::BYTES_OPCODE) begin
                  s_nxt.write_enable_latch = 1'b1;
               end else begin
                  s_nxt.reject = 1'b1;
               end
            end
            flash_front_pkg::CMD_WRITE_DISABLE: begin
               acc = on_byte && !s_r.busy;
            end
            flash_front_pkg::CMD_WRITE_STATUS: begin
               // [RQ24] pin lock on level bits
               if (ok_wr && l_r.byte_cnt == flash_front_pkg::BYTES_STATUS && !hw_lock) begin
                  s_nxt.level = l_r.value[flash_front_pkg::ST_LVL_LSB +: 4];
                  s_nxt.swd   = l_r.value[flash_front_pkg::ST_SWD];
                  acc = 1'b1;
               end
            end
            flash_front_pkg::CMD_PAGE_PROGRAM: begin
               if (ok_wr && l_r.byte_cnt >= flash_front_pkg::BYTES_PROGRAM) begin
                  s_nxt.addr = a;
                  if (s_r.secure) begin
                     // [RQ4] half select
                     // [RQ7] locked half refused
                     acc = !(a[flash_front_pkg::OTP_HALF_BIT]
                             ? s_r.sec[flash_front_pkg::SEC_FACTORY]
                             : s_r.sec[flash_front_pkg::SEC_CUSTOMER]);
                     s_nxt.otp_req = acc;
                  end else begin
                     // [RQ25] protected target dropped
                     acc = !blk_protected(s_r.level, i_top_bottom_select, blk);
                     s_nxt.prog_req = acc;
                  end
               end
            end
            flash_front_pkg::CMD_SECTOR_ERASE, flash_front_pkg::CMD_HALF_ERASE,
            flash_front_pkg::CMD_BLOCK_ERASE: begin
               // [RQ8] array denied in secure mode
               // [RQ1] [RQ2] level decode
               if (ok_wr && l_r.byte_cnt == flash_front_pkg::BYTES_ADDR && !s_r.secure
                   && !blk_protected(s_r.level, i_top_bottom_select, blk)) begin
                  acc = 1'b1;
                  s_nxt.erase_req = 1'b1;
                  // [RQ9] size alignment
                  if (l_r.opcode == flash_front_pkg::CMD_SECTOR_ERASE) begin
                     s_nxt.erase_kind = flash_front_pkg::ERASE_SECTOR;
                     s_nxt.addr = a & ({flash_front_pkg::ADDR_BITS{1'b1}}
                                       << flash_front_pkg::SECTOR_LSB);
                  end else if (l_r.opcode == flash_front_pkg::CMD_HALF_ERASE) begin
                     s_nxt.erase_kind = flash_front_pkg::ERASE_HALF_BLOCK;
                     s_nxt.addr = a & ({flash_front_pkg::ADDR_BITS{1'b1}}
                                       << flash_front_pkg::HALF_BLK_LSB);
                  end else begin
                     s_nxt.erase_kind = flash_front_pkg::ERASE_BLOCK;
                     s_nxt.addr = a & ({flash_front_pkg::ADDR_BITS{1'b1}}
                                       << flash_front_pkg::BLK_LSB);
                  end
               end
            end
            flash_front_pkg::CMD_CHIP_ERASE_A, flash_front_pkg::CMD_CHIP_ERASE_B: begin
               // [RQ3] chip erase only at level zero
               if (ok_wr && l_r.byte_cnt == flash_front_pkg::BYTES_OPCODE && !s_r.secure
                   && s_r.level == flash_front_pkg::LEVEL_NONE) begin
                  acc = 1'b1;
                  s_nxt.erase_req  = 1'b1;
                  s_nxt.erase_kind = flash_front_pkg::ERASE_CHIP;
                  s_nxt.addr       = '0;
               end
            end
            CMD_ENTER_SECURE, CMD_EXIT_SECURE: begin
               acc = on_byte && !s_r.busy && l_r.byte_cnt == flash_front_pkg::BYTES_OPCODE;
               if (acc) begin
                  s_nxt.secure = (l_r.opcode == CMD_ENTER_SECURE);
               end
            end
            CMD_WRITE_SECURE: begin
               // [RQ6] customer lock set
               if (ok_wr && l_r.byte_cnt == flash_front_pkg::BYTES_OPCODE) begin
                  acc = 1'b1;
                  s_nxt.sec[flash_front_pkg::SEC_CUSTOMER] = 1'b1;
               end
            end
            default: is_wr = 1'b0;
         endcase
         if (l_r.opcode != flash_front_pkg::CMD_WRITE_ENABLE && is_wr) begin
            s_nxt.reject = !acc;
            if (acc) begin
               s_nxt.write_enable_latch = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         s_r <= '{cs1: 1'b1, cs2: 1'b1, cs3: 1'b1, wp1: 1'b1, wp2: 1'b1, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // [RQ19] output released in pause
   assign o_so                   = o_r.so;
   assign o_so_oe                = o_r.so_oe;
   assign o_protect_level        = s_r.level;
   assign o_status_write_disable = s_r.swd;
   assign o_write_enable_latch   = s_r.write_enable_latch;
   assign o_security_reg         = s_r.sec;
   assign o_secure_area_mode     = s_r.secure;
   assign o_prog_req             = s_r.prog_req;
   assign o_otp_prog_req         = s_r.otp_req;
   assign o_erase_req            = s_r.erase_req;
   assign o_erase_kind           = s_r.erase_kind;
   assign o_addr                 = s_r.addr;
   assign o_cmd_reject           = s_r.reject;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_chip_level;  // [RQ3]
      @(posedge i_ref_clk) disable iff (i_rst)
         s_r.erase_req && s_r.erase_kind == flash_front_pkg::ERASE_CHIP
            |-> s_r.level == flash_front_pkg::LEVEL_NONE;
   endproperty
   a_chip_level: assert property (p_chip_level)  // [RQ3]
      else $error("chip erase with level set");

   property p_erase_unprot;  // [RQ25]
      @(posedge i_ref_clk) disable iff (i_rst)
         (s_r.erase_req && s_r.erase_kind != flash_front_pkg::ERASE_CHIP) || s_r.prog_req
            |-> !blk_protected(s_r.level, $past(i_top_bottom_select),
                               s_r.addr[flash_front_pkg::BLK_LSB +: 2]);
   endproperty
   a_erase_unprot: assert property (p_erase_unprot)  // [RQ25]
      else $error("protected block hit");

   property p_otp_lock;  // [RQ7]
      @(posedge i_ref_clk) disable iff (i_rst)
         s_r.otp_req |-> !(s_r.addr[flash_front_pkg::OTP_HALF_BIT]
                           ? $past(s_r.sec[flash_front_pkg::SEC_FACTORY])
                           : s_r.sec[flash_front_pkg::SEC_CUSTOMER]);
   endproperty
   a_otp_lock: assert property (p_otp_lock)  // [RQ7]
      else $error("locked secure half changed");

   property p_cust_lock;  // [RQ6]
      @(posedge i_ref_clk) disable iff (i_rst)
         $rose(s_r.sec[flash_front_pkg::SEC_CUSTOMER]) |-> $past(frame_done)
            && $past(l_r.opcode) == CMD_WRITE_SECURE && $past(s_r.write_enable_latch);
   endproperty
   a_cust_lock: assert property (p_cust_lock)  // [RQ6]
      else $error("customer lock without command");

   property p_secure_no_array;  // [RQ8]
      @(posedge i_ref_clk) disable iff (i_rst)
         $past(s_r.secure) |-> !s_r.erase_req && !s_r.prog_req;
   endproperty
   a_secure_no_array: assert property (p_secure_no_array)  // [RQ8]
      else $error("array hit in secure");

   property p_busy_ignore;  // [RQ15]
      @(posedge i_ref_clk) disable iff (i_rst)
         frame_done && s_r.busy |=> !s_r.prog_req && !s_r.erase_req && !s_r.otp_req;
   endproperty
   a_busy_ignore: assert property (p_busy_ignore)  // [RQ15]
      else $error("request while busy");

   property p_wel_needed;  // [RQ23]
      @(posedge i_ref_clk) disable iff (i_rst)
         s_r.prog_req || s_r.erase_req || s_r.otp_req |-> $past(s_r.write_enable_latch) && !s_r.write_enable_latch;
   endproperty
   a_wel_needed: assert property (p_wel_needed)  // [RQ23]
      else $error("write without latch");

   property p_pin_lock;  // [RQ24]
      @(posedge i_ref_clk) disable iff (i_rst)
         s_r.swd && !s_r.wp2 && !s_r.quad ##1 s_r.swd |-> $stable(s_r.level);
   endproperty
   a_pin_lock: assert property (p_pin_lock)  // [RQ24]
      else $error("level changed under pin lock");

   property p_boundary;  // [RQ14]
      @(posedge i_ref_clk) disable iff (i_rst)
         frame_done && l_r.bit_cnt != '0 |=> !s_r.prog_req && !s_r.erase_req
            && !s_r.otp_req;
   endproperty
   a_boundary: assert property (p_boundary)  // [RQ14]
      else $error("partial byte accepted");

   property p_pause_hiz;  // [RQ19]
      @(negedge i_sclk) disable iff (i_cs_n)
         !i_hold_n && !l_r.sync2[flash_front_pkg::SYNC_QUAD] |=> !o_r.so_oe;
   endproperty
   a_pause_hiz: assert property (p_pause_hiz)  // [RQ19]
      else $error("output driven in pause");

endmodule

//--- hw/flash_front_pkg.sv
// constants and types shared by the serial flash front end
package flash_front_pkg;

   // ------------------------------------------------------------
   // command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] CMD_READ_STATUS   = 8'h05;
   localparam logic [7:0] CMD_WRITE_STATUS  = 8'h01;
   localparam logic [7:0] CMD_READ          = 8'h03;
   localparam logic [7:0] CMD_FAST_READ     = 8'h0b;
   localparam logic [7:0] CMD_PAGE_PROGRAM  = 8'h02;
   localparam logic [7:0] CMD_SECTOR_ERASE  = 8'h20;
   localparam logic [7:0] CMD_HALF_ERASE    = 8'h52;
   localparam logic [7:0] CMD_BLOCK_ERASE   = 8'hd8;
   localparam logic [7:0] CMD_CHIP_ERASE_A  = 8'h60;
   localparam logic [7:0] CMD_CHIP_ERASE_B  = 8'hc7;

   // ------------------------------------------------------------
   // array layout
   // ------------------------------------------------------------
   localparam int ADDR_BITS    = 18;  // 000000h..03ffffh
   localparam int BLK_LSB      = 16;  // 64KB blocks
   localparam int HALF_BLK_LSB = 15;  // 32KB blocks
   localparam int SECTOR_LSB   = 12;  // 4KB sectors
   localparam int OTP_HALF_BIT = 9;   // 000-1ff customer, 200-3ff factory

   // ------------------------------------------------------------
   // status and security bit positions, frame lengths
   // ------------------------------------------------------------
   localparam int ST_BUSY    = 0;
   localparam int ST_WEL     = 1;
   localparam int ST_LVL_LSB = 2;
   localparam int ST_SWD     = 7;
   localparam int SYNC_QUAD  = 8;
   localparam int SEC_FACTORY  = 0;
   localparam int SEC_CUSTOMER = 1;
   localparam logic [2:0] STATUS_MSB    = 3'h7;
   localparam logic [2:0] LAST_BIT      = 3'h7;
   localparam logic [2:0] BYTES_OPCODE  = 3'h1;
   localparam logic [2:0] BYTES_STATUS  = 3'h2;
   localparam logic [2:0] BYTES_ADDR    = 3'h4;
   localparam logic [2:0] BYTES_PROGRAM = 3'h5;
   localparam logic [2:0] BYTES_SAT     = 3'h7;
   localparam logic [3:0] LEVEL_NONE    = 4'h0;
   localparam logic [3:0] LEVEL_ONE     = 4'h1;
   localparam logic [3:0] LEVEL_TWO     = 4'h2;
   localparam logic [1:0] BLK_FIRST     = 2'h0;
   localparam logic [1:0] BLK_SECOND    = 2'h1;
   localparam logic [1:0] BLK_LAST      = 2'h3;

   typedef enum logic [1:0] {ERASE_SECTOR, ERASE_HALF_BLOCK, ERASE_BLOCK, ERASE_CHIP} erase_kind_e;

endpackage

//--- sim/spi_host_model.sv
// serial bus host model: drives frames on select, clock and data
`timescale 1ns/1ps
module spi_host_model (
   output logic      o_cs_n,
   output logic      o_sclk,
   output logic      o_si,
   input  wire logic i_so
);
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_si   = 1'b1;
   end
   // one frame, msb first, clock only inside the frame, bits 8..15 read back
   // mode 0 edges
   task automatic frame(input logic [39:0] d, input int n, output logic [7:0] rd);
      int i;
      rd = 8'h00;
      o_cs_n = 1'b0;
      for (i = 0; i < n; i++) begin
         o_si = d[39-i];
         #6 o_sclk = 1'b1;
         if (i >= 8 && i < 16) rd = {rd[6:0], i_so};
         #6 o_sclk = 1'b0;
      end
      // select rises where the caller chose
      #6 o_cs_n = 1'b1;
      o_si = ~o_si;
   endtask
endmodule

//--- sim/testbench.sv
// self-checking bench for the serial flash front end
`timescale 1ns/1ps
module testbench;
   logic i_ref_clk = 1'b0, i_rst = 1'b1, i_hold_n = 1'b1, i_wp_n = 1'b1;
   logic i_quad_mode = 1'b0, i_top_bottom_select = 1'b0, i_factory_otp_lock = 1'b0;
   logic i_busy = 1'b0, i_sclk, i_cs_n, i_si, o_so, o_so_oe, o_status_write_disable;
   logic o_write_enable_latch, o_secure_area_mode, o_prog_req, o_otp_prog_req;
   logic o_erase_req, o_cmd_reject, ers, rej;
   logic [3:0] o_protect_level;
   logic [1:0] o_security_reg, o_erase_kind;
   logic [17:0] o_addr;
   logic [7:0] rd;
   logic [1:0] prg;
   int n_errors = 0, compares = 0;
   always #50 i_ref_clk = ~i_ref_clk;
   spi_host_model host (.o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_si(i_si),
      .i_so(o_so_oe ? o_so : ~o_so));
   flash_front dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
      .i_si(i_si), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .i_quad_mode(i_quad_mode),
      .i_top_bottom_select(i_top_bottom_select), .i_factory_otp_lock(i_factory_otp_lock),
      .i_busy(i_busy), .o_so(o_so), .o_so_oe(o_so_oe), .o_protect_level(o_protect_level),
      .o_status_write_disable(o_status_write_disable), .o_prog_req(o_prog_req),
      .o_write_enable_latch(o_write_enable_latch), .o_security_reg(o_security_reg),
      .o_secure_area_mode(o_secure_area_mode), .o_otp_prog_req(o_otp_prog_req),
      .o_erase_req(o_erase_req), .o_erase_kind(o_erase_kind), .o_addr(o_addr),
      .o_cmd_reject(o_cmd_reject));
   // catch one-cycle request and refusal pulses
   always @(posedge i_ref_clk) begin
      if (o_erase_req) ers <= 1'b1;
      if (o_cmd_reject) rej <= 1'b1;
      prg <= prg | {o_otp_prog_req, o_prog_req};
   end
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic run(input logic [39:0] d, input int n);
      ers = 1'b0;
      rej = 1'b0;
      prg = 2'b00;
      host.frame(d, n, rd);
      repeat (10) @(posedge i_ref_clk);
   endtask
   task automatic wr();
      run({flash_front_pkg::CMD_WRITE_ENABLE, 32'h0}, 8);
   endtask
   task automatic ers_at(input logic [7:0] op, input logic [23:0] a, input int n);
      wr();
      run({op, a, 8'h00}, n);
   endtask
   task automatic prog(input logic [23:0] a);
      ers_at(flash_front_pkg::CMD_PAGE_PROGRAM, a, 40);
   endtask
   task automatic close_out();
      $display("errors=%0d compares=%0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #200000 n_errors++;
      close_out();
   end
   initial begin
      repeat (12) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      wr();
      check(o_write_enable_latch, 24'h1);
      run({flash_front_pkg::CMD_READ_STATUS, 32'h0}, 16);
      check(rd, 24'h02);
      run({8'hff, 32'h0}, 16);
      check({rej, rd}, 24'h0ff);
      run({flash_front_pkg::CMD_SECTOR_ERASE, 24'h012345, 8'h0}, 32);
      check({ers, o_erase_kind, o_addr}, {1'b1, 2'h0, 18'h12000});
      run({flash_front_pkg::CMD_SECTOR_ERASE, 24'h012345, 8'h0}, 32);
      check(rej, 24'h1);
      wr();
      run({flash_front_pkg::CMD_SECTOR_ERASE, 24'h012345, 8'h0}, 30);
      check({rej, ers}, 24'h2);
      ers_at(flash_front_pkg::CMD_CHIP_ERASE_B, 24'h0, 8);
      check({ers, o_erase_kind}, 24'h7);
      wr();
      run({flash_front_pkg::CMD_WRITE_STATUS, 8'h04, 24'h0}, 16);
      check(o_protect_level, 24'h1);
      fork
         run({flash_front_pkg::CMD_READ_STATUS, 32'h0}, 16);
         begin
            #99 i_hold_n <= 1'b0;
            #24 i_hold_n <= 1'b1;
         end
      join
      check(rd, 24'h61);
      ers_at(flash_front_pkg::CMD_BLOCK_ERASE, 24'h030000, 32);
      check({rej, ers}, 24'h2);
      ers_at(flash_front_pkg::CMD_BLOCK_ERASE, 24'h000000, 32);
      check({rej, ers}, 24'h1);
      ers_at(flash_front_pkg::CMD_CHIP_ERASE_A, 24'h0, 8);
      check({rej, ers}, 24'h2);
      i_top_bottom_select <= 1'b1;
      ers_at(flash_front_pkg::CMD_BLOCK_ERASE, 24'h000000, 32);
      check({rej, ers}, 24'h2);
      wr();
      i_busy <= 1'b1;
      run({flash_front_pkg::CMD_BLOCK_ERASE, 24'h030000, 8'h0}, 32);
      check({rej, ers}, 24'h2);
      i_busy <= 1'b0;
      i_factory_otp_lock <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      check(o_security_reg[0], 24'h1);
      prog(24'h030010);
      check({prg, o_addr}, {2'h1, 18'h30010});
      prog(24'h000010);
      check({rej, prg}, 24'h4);
      run({dut.CMD_ENTER_SECURE, 32'h0}, 8);
      check(o_secure_area_mode, 24'h1);
      prog(24'h000010);
      check({prg, o_addr}, {2'h2, 18'h00010});
      ers_at(flash_front_pkg::CMD_SECTOR_ERASE, 24'h030000, 32);
      check({rej, ers}, 24'h2);
      ers_at(dut.CMD_WRITE_SECURE, 24'h0, 8);
      check(o_security_reg, 24'h3);
      prog(24'h000010);
      check({rej, prg}, 24'h4);
      prog(24'h000210);
      check({rej, prg}, 24'h4);
      run({dut.CMD_EXIT_SECURE, 32'h0}, 8);
      check(o_secure_area_mode, 24'h0);
      ers_at(flash_front_pkg::CMD_WRITE_STATUS, 24'h800000, 16);
      check({o_status_write_disable, o_protect_level}, 24'h10);
      i_wp_n <= 1'b0;
      ers_at(flash_front_pkg::CMD_WRITE_STATUS, 24'h0c0000, 16);
      check({rej, o_protect_level}, 24'h10);
      i_quad_mode <= 1'b1;
      ers_at(flash_front_pkg::CMD_WRITE_STATUS, 24'h0c0000, 16);
      check({o_status_write_disable, o_protect_level}, 24'h03);
      close_out();
   end
endmodule
